// ### verilog/bib_top.v
// lpc bridge: window decode, isa forwarding and irq routing
//
// Behaviour
// - each source routed to irq 3-11, not 8
// - several sources may share one line
// - non-serial status sticks until write-one
// - serial port irqs pass through, not latched
// - enabled slot driven in every frame
// - slot high when pending, low otherwise
// - eleven isa irq inputs, enables cleared at reset
// - enabled isa irqs pass straight to slot
// - claim io only in 0xc80 to 0xcbf
// - byte cycles only; host splits wider
// - word registers at aligned adjacent bytes
// - timer at 0xcbc to 0xcbf, 4-aligned
// - io outside window goes to isa
// - memory below 16 mbytes goes to isa
// - memory at 0x1000000 and up ignored
// - isa memory 24 bits, isa io 16 bits
`timescale 1ns/1ns
`include "bib_defines.vh"

module bib_top #(
    parameter NSRC = 8                       // latched on-board sources
) (
    input  wire                 CLK_IN,          // system clock
    input  wire                 RST_N_IN,        // async reset, low

    // decoded lpc cycle from the lpc front end
    input  wire                 CYC_VALID_IN,    // one-cycle strobe
    input  wire                 CYC_MEM_IN,      // 1 memory, 0 io
    input  wire                 CYC_WRITE_IN,    // 1 write, 0 read
    input  wire [1:0]           CYC_SIZE_IN,     // 0 byte
    input  wire [31:0]          CYC_ADDR_IN,     // lpc address
    input  wire [7:0]           CYC_WDATA_IN,    // write byte

    // local register port
    output reg                  LOC_REQ_OUT,     // board register cycle
    output reg                  TMR_REQ_OUT,     // timer cycle
    output reg  [5:0]           LOC_OFF_OUT,     // window offset
    output reg                  LOC_WRITE_OUT,   // write flag
    output reg  [7:0]           LOC_WDATA_OUT,   // write byte

    // expansion bus request
    output reg                  ISA_IO_REQ_OUT,  // io cycle strobe
    output reg                  ISA_MEM_REQ_OUT, // memory cycle strobe
    output reg  [23:0]          ISA_ADDR_OUT,    // truncated address
    output reg                  ISA_WRITE_OUT,   // write flag
    output reg  [7:0]           ISA_WDATA_OUT,   // write byte
    output reg                  CYC_DROP_OUT,    // cycle not taken

    // on-board latched sources
    input  wire [NSRC-1:0]      SRC_EVT_IN,      // event pulses
    input  wire [NSRC-1:0]      SRC_CLR_IN,      // write-one clears
    input  wire [NSRC-1:0]      SRC_EN_IN,       // per source enable
    input  wire [3*NSRC-1:0]    SRC_SEL_IN,      // line select codes
    output wire [NSRC-1:0]      SRC_STAT_OUT,    // sticky status

    // serial port sources
    input  wire [1:0]           UART_IRQ_IN,     // controller irq level
    input  wire [1:0]           UART_EN_IN,      // enables
    input  wire [5:0]           UART_SEL_IN,     // line select codes

    // expansion bus irqs
    input  wire [10:0]          ISA_IRQ_IN,      // pin levels
    input  wire                 ISA_EN_WR_IN,    // enable write strobe
    input  wire [10:0]          ISA_EN_WDATA_IN, // new enable bits
    output wire [10:0]          ISA_EN_OUT,      // enables in force

    // serial irq pin
    input  wire                 SERIRQ_IN,       // pin level
    output wire                 SERIRQ_OUT,      // driven level
    output wire                 SERIRQ_OE_OUT    // high while driving
);

    // ------------
    // constants
    // ------------

    localparam NTOT = NSRC + 2;                  // all routable sources
    localparam [15:0] WIN_BASE = `BIB_WIN_BASE;  // window start
    localparam [15:0] WIN_LAST = `BIB_WIN_LAST;  // window end
    localparam [31:0] MEM_LIM  = `BIB_MEM_LIMIT; // isa memory top
    localparam [5:0]  TMR_OFF  = `BIB_TMR_OFF;   // timer block offset

    // ------------
    // line select helpers
    // ------------

    // irq 8 is never offered to a source
    // code 0..7 picks irq 3,4,5,6,7,9,10,11
    function [3:0] sel_line;
        input [2:0] code;
        begin
            case (code)
                3'h0:    sel_line = 4'h3;
                3'h1:    sel_line = 4'h4;
                3'h2:    sel_line = 4'h5;
                3'h3:    sel_line = 4'h6;
                3'h4:    sel_line = 4'h7;
                3'h5:    sel_line = 4'h9;
                3'h6:    sel_line = 4'hA;
                default: sel_line = 4'hB;
            endcase
        end
    endfunction

    // isa input index 0..10 to its irq number
    // irq 13 has no expansion bus input
    function [3:0] isa_line;
        input integer idx;
        begin
            case (idx)
                0:       isa_line = 4'h3;
                1:       isa_line = 4'h4;
                2:       isa_line = 4'h5;
                3:       isa_line = 4'h6;
                4:       isa_line = 4'h7;
                5:       isa_line = 4'h9;
                6:       isa_line = 4'hA;
                7:       isa_line = 4'hB;
                8:       isa_line = 4'hC;
                9:       isa_line = 4'hE;
                default: isa_line = 4'hF;
            endcase
        end
    endfunction

    // ------------
    // cycle decode
    // ------------

    wire        in_win;    // io address inside own window
    wire        is_tmr;    // io address in timer block
    wire        is_byte;   // byte sized cycle
    wire        mem_low;   // memory address below limit
    wire [15:0] io_addr;   // io address bits

    assign io_addr = CYC_ADDR_IN[15:0];

    // 64-byte window, upper bits must match
    // a nonzero upper half is forwarded, never claimed
    assign in_win  = (CYC_ADDR_IN[31:16] == 16'h0000) &&
                     (io_addr >= WIN_BASE) && (io_addr <= WIN_LAST);

    // last four bytes, base on a 4-byte boundary
    assign is_tmr  = in_win && (io_addr[5:2] == TMR_OFF[5:2]);

    assign is_byte = (CYC_SIZE_IN == `BIB_SIZE_BYTE);

    // below 16 mbytes only
    assign mem_low = (CYC_ADDR_IN < MEM_LIM);

    // ------------
    // cycle steering, registered one-cycle strobes
    // ------------

    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            LOC_REQ_OUT     <= 1'b0;
            TMR_REQ_OUT     <= 1'b0;
            LOC_OFF_OUT     <= 6'h00;
            LOC_WRITE_OUT   <= 1'b0;
            LOC_WDATA_OUT   <= 8'h00;
            ISA_IO_REQ_OUT  <= 1'b0;
            ISA_MEM_REQ_OUT <= 1'b0;
            ISA_ADDR_OUT    <= 24'h00_0000;
            ISA_WRITE_OUT   <= 1'b0;
            ISA_WDATA_OUT   <= 8'h00;
            CYC_DROP_OUT    <= 1'b0;
        end else begin
            // strobes fall back after one cycle
            LOC_REQ_OUT     <= 1'b0;
            TMR_REQ_OUT     <= 1'b0;
            ISA_IO_REQ_OUT  <= 1'b0;
            ISA_MEM_REQ_OUT <= 1'b0;
            CYC_DROP_OUT    <= 1'b0;
            // address and data hold until the next cycle
            // of their kind, so slow far ends may read late
            // exactly one strobe answers each cycle
            if (CYC_VALID_IN) begin
                if (!CYC_MEM_IN && in_win) begin
                    // own window; byte cycles only
                    if (is_byte) begin
                        // byte offset kept whole, so word
                        // halves land in adjacent bytes
                        LOC_OFF_OUT   <= io_addr[5:0];
                        LOC_WRITE_OUT <= CYC_WRITE_IN;
                        LOC_WDATA_OUT <= CYC_WDATA_IN;
                        LOC_REQ_OUT   <= !is_tmr;
                        TMR_REQ_OUT   <= is_tmr;
                    end else begin
                        CYC_DROP_OUT  <= 1'b1;
                    end
                end else if (!CYC_MEM_IN) begin
                    // unclaimed io to isa, 16 bits
                    ISA_IO_REQ_OUT <= 1'b1;
                    ISA_ADDR_OUT   <= {8'h00, io_addr};
                    ISA_WRITE_OUT  <= CYC_WRITE_IN;
                    ISA_WDATA_OUT  <= CYC_WDATA_IN;
                end else if (mem_low) begin
                    // low memory to isa, 24 bits
                    ISA_MEM_REQ_OUT <= 1'b1;
                    ISA_ADDR_OUT    <= CYC_ADDR_IN[23:0];
                    ISA_WRITE_OUT   <= CYC_WRITE_IN;
                    ISA_WDATA_OUT   <= CYC_WDATA_IN;
                end else begin
                    // high memory left alone
                    CYC_DROP_OUT    <= 1'b1;
                end
            end
        end
    end

    // ------------
    // sticky status for latched sources
    // ------------

    reg  [NSRC-1:0] stat_q;  // sticky status bits
    wire [NSRC-1:0] stat_d;  // next status

    // status ignores the enable, which only gates routing
    // event wins over a clear in the same cycle
    assign stat_d       = (stat_q & ~SRC_CLR_IN) | SRC_EVT_IN;

    assign SRC_STAT_OUT = stat_q;

    // status register
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            stat_q <= {NSRC{1'b0}};
        end else begin
            stat_q <= stat_d;
        end
    end

    // ------------
    // isa irq enables and input synchroniser
    // ------------

    reg  [10:0] isa_en_q;    // enable bits
    reg  [10:0] isa_s1_q;    // first sync stage
    reg  [10:0] isa_s2_q;    // second sync stage

    assign ISA_EN_OUT = isa_en_q;
    // pins are asynchronous: only stage two is read

    // enables cleared after reset
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            isa_en_q <= 11'h000;
            isa_s1_q <= 11'h000;
            isa_s2_q <= 11'h000;
        end else begin
            if (ISA_EN_WR_IN) begin
                isa_en_q <= ISA_EN_WDATA_IN;
            end
            isa_s1_q <= ISA_IRQ_IN;
            isa_s2_q <= isa_s1_q;
        end
    end

    // ------------
    // on-board routing, one stage per source
    // ------------

    wire [15:0] src_act [0:NTOT];  // running or of enabled lines
    wire [15:0] src_pnd [0:NTOT];  // running or of pending lines
    wire [NTOT-1:0] all_en;        // enables, uarts on top
    wire [NTOT-1:0] all_lvl;       // levels, uarts on top
    wire [3*NTOT-1:0] all_sel;     // select codes, uarts on top

    assign all_en  = {UART_EN_IN, SRC_EN_IN};
    // uarts feed their own level, not latched
    assign all_lvl = {UART_IRQ_IN, stat_q};
    assign all_sel = {UART_SEL_IN, SRC_SEL_IN};

    assign src_act[0] = 16'h0000;
    assign src_pnd[0] = 16'h0000;

    genvar gi;
    generate
        for (gi = 0; gi < NTOT; gi = gi + 1) begin : g_src
            wire [3:0]  line;   // chosen irq number
            wire [15:0] mask;   // one-hot line mask

            // select from irq 3..11 without 8
            assign line = sel_line(all_sel[3*gi +: 3]);
            // a disabled source leaves its line alone
            assign mask = all_en[gi] ? (16'h0001 << line) : 16'h0000;
            // shared lines merge by or
            assign src_act[gi+1] = src_act[gi] | mask;
            assign src_pnd[gi+1] = src_pnd[gi] |
                                   (all_lvl[gi] ? mask : 16'h0000);
        end
    endgenerate

    // ------------
    // isa routing, one stage per input
    // ------------

    wire [15:0] isa_act [0:11];  // running or of enabled lines
    wire [15:0] isa_pnd [0:11];  // running or of pending lines

    assign isa_act[0] = 16'h0000;
    assign isa_pnd[0] = 16'h0000;

    generate
        for (gi = 0; gi < 11; gi = gi + 1) begin : g_isa
            wire [15:0] mask;   // one-hot line mask

            // a disabled input leaves its line alone
            assign mask = isa_en_q[gi] ?
                          (16'h0001 << isa_line(gi)) : 16'h0000;
            // straight through, no capture
            assign isa_act[gi+1] = isa_act[gi] | mask;
            assign isa_pnd[gi+1] = isa_pnd[gi] |
                                   (isa_s2_q[gi] ? mask : 16'h0000);
        end
    endgenerate

    // ------------
    // slot vectors and serial irq engine
    // ------------

    wire [15:0] slot_act;  // slots to drive
    wire [15:0] slot_pnd;  // slots to drive high

    // slots 0-2, 8 and 13 have no source, never driven
    // any enabled source on a line marks it
    assign slot_act = src_act[NTOT] | isa_act[11];
    assign slot_pnd = src_pnd[NTOT] | isa_pnd[11];

    // the pin is released outside the driven phase
    // frame tracking and slot drive
    bib_serirq u_serirq (
        .clk_in        (CLK_IN),
        .rst_n_in      (RST_N_IN),
        .serirq_in     (SERIRQ_IN),
        .active_in     (slot_act),
        .pending_in    (slot_pnd),
        .serirq_out    (SERIRQ_OUT),
        .serirq_oe_out (SERIRQ_OE_OUT)
    );

endmodule

// ### verilog/bib_defines.vh
// constants for the lpc bridge, window decode and interrupt router
`ifndef BIB_DEFINES_VH
`define BIB_DEFINES_VH

// ------------
// lpc i/o window
// ------------
`define BIB_WIN_BASE      16'h0C80
`define BIB_WIN_LAST      16'h0CBF
`define BIB_TMR_BASE      16'h0CBC
`define BIB_TMR_OFF       6'h3C
`define BIB_OFF_W         6

// ------------
// expansion bus address limits
// ------------
`define BIB_MEM_LIMIT     32'h0100_0000
`define BIB_ISA_MEM_W     24
`define BIB_ISA_IO_W      16

// ------------
// cycle size codes
// ------------
`define BIB_SIZE_BYTE     2'h0

// ------------
// legacy irq select codes, three bits per source
// ------------
`define BIB_SEL_W         3
`define BIB_NUM_LINES     16
`define BIB_NUM_ISA_IRQ   11

// ------------
// serial irq frame timing, in clocks
// ------------
`define BIB_SLOT_CLKS     2'h3
`define BIB_START_MIN     3'h4
`define BIB_NUM_SLOTS     5'h15

`endif

// ### verilog/bib_serirq.v
// serial irq slot engine: frame tracking and slot driving
`timescale 1ns/1ns
`include "bib_defines.vh"

module bib_serirq (
    input  wire        clk_in,       // system clock
    input  wire        rst_n_in,     // async reset, active low
    input  wire        serirq_in,    // serial irq pin level
    input  wire [15:0] active_in,    // slots with an enabled source
    input  wire [15:0] pending_in,   // slots with a pending irq
    output wire        serirq_out,   // driven level
    output wire        serirq_oe_out // high while driving
);

    // ------------
    // states
    // ------------
    localparam [1:0] ST_IDLE  = 2'b01; // waiting for start frame
    localparam [1:0] ST_SLOTS = 2'b10; // walking the slots

    reg  [1:0] state_q;   // frame state
    reg  [1:0] state_d;
    reg        sync1_q;   // first synchroniser stage
    reg        sync2_q;   // second synchroniser stage
    reg  [2:0] low_q;     // low clocks seen, saturating
    reg  [2:0] low_d;
    reg  [1:0] ph_q;      // phase inside a slot
    reg  [1:0] ph_d;
    reg  [4:0] slot_q;    // current slot number
    reg  [4:0] slot_d;
    reg        drv_q;     // registered output enable
    reg        lvl_q;     // registered output level
    wire       in_slot;   // slot maps to an irq line

    assign in_slot       = (slot_q < 5'h10);
    assign serirq_out    = lvl_q;
    assign serirq_oe_out = drv_q;

    // ------------
    // next state
    // ------------
    always @* begin
        state_d = state_q;
        low_d   = low_q;
        ph_d    = ph_q;
        slot_d  = slot_q;
        case (state_q)
            ST_IDLE: begin
                // start frame is a long low then high
                if (!sync2_q) begin
                    if (low_q != 3'h7) begin
                        low_d = low_q + 3'h1;
                    end
                end else begin
                    if (low_q >= `BIB_START_MIN) begin
                        state_d = ST_SLOTS;
                        ph_d    = 2'h0;
                        slot_d  = 5'h00;
                    end
                    low_d = 3'h0;
                end
            end
            ST_SLOTS: begin
                // sample, drive, turnaround in each slot
                if (ph_q == `BIB_SLOT_CLKS - 2'h1) begin
                    ph_d = 2'h0;
                    if (slot_q == `BIB_NUM_SLOTS - 5'h01) begin
                        state_d = ST_IDLE;
                    end else begin
                        slot_d = slot_q + 5'h01;
                    end
                end else begin
                    ph_d = ph_q + 2'h1;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ------------
    // registers; drive falls in phase one of the slot
    // ------------
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= ST_IDLE;
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            low_q   <= 3'h0;
            ph_q    <= 2'h0;
            slot_q  <= 5'h00;
            drv_q   <= 1'b0;
            lvl_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            sync1_q <= serirq_in;
            sync2_q <= sync1_q;
            low_q   <= low_d;
            ph_q    <= ph_d;
            slot_q  <= slot_d;
            // every frame, every enabled slot
            drv_q   <= (state_q == ST_SLOTS) && (ph_q == 2'h0) &&
                       in_slot && active_in[slot_q[3:0]];
            // high when pending, low when idle
            lvl_q   <= in_slot && pending_in[slot_q[3:0]];
        end
    end

endmodule

// ### tb/bib_top_properties.sv
// assertions on the bridge top ports
`timescale 1ns/1ns
module bib_top_checker #(
    parameter NSRC = 8                  // latched source count
) (
    input wire              CLK_IN,
    input wire              RST_N_IN,
    input wire              CYC_VALID_IN,
    input wire              CYC_MEM_IN,
    input wire [1:0]        CYC_SIZE_IN,
    input wire [31:0]       CYC_ADDR_IN,
    input wire              LOC_REQ_OUT,
    input wire              TMR_REQ_OUT,
    input wire [5:0]        LOC_OFF_OUT,
    input wire              ISA_IO_REQ_OUT,
    input wire              ISA_MEM_REQ_OUT,
    input wire [23:0]       ISA_ADDR_OUT,
    input wire              CYC_DROP_OUT,
    input wire [NSRC-1:0]   SRC_EVT_IN,
    input wire [NSRC-1:0]   SRC_CLR_IN,
    input wire [NSRC-1:0]   SRC_STAT_OUT,
    input wire              ISA_EN_WR_IN,
    input wire [10:0]       ISA_EN_WDATA_IN,
    input wire [10:0]       ISA_EN_OUT,
    input wire              SERIRQ_OE_OUT
);
    // ------------
    // decode helpers
    // ------------
    wire [4:0] strb = {CYC_DROP_OUT, ISA_MEM_REQ_OUT, ISA_IO_REQ_OUT,
                       TMR_REQ_OUT, LOC_REQ_OUT};   // answer strobes
    wire       win  = !CYC_MEM_IN && CYC_ADDR_IN >= 32'h0000_0C80
                      && CYC_ADDR_IN <= 32'h0000_0CBF; // own io window
    wire       byt  = CYC_SIZE_IN == 2'h0;          // byte cycle
    wire       tmrh = CYC_ADDR_IN >= 32'h0000_0CBC; // timer part
    wire       low  = CYC_ADDR_IN < 32'h0100_0000;  // below 16 mbytes
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // ------------
    // properties
    // ------------
    a_one_answer: assert property (
        CYC_VALID_IN |=> $onehot(strb)) else $error("answer not single");
    a_quiet_idle: assert property (
        !CYC_VALID_IN |=> strb == 5'h0) else $error("spurious strobe");
    a_board_claim: assert property (
        CYC_VALID_IN && win && byt && !tmrh |=> LOC_REQ_OUT
        && LOC_OFF_OUT == $past(CYC_ADDR_IN[5:0])) else $error("board miss");
    a_timer_claim: assert property (
        CYC_VALID_IN && win && byt && tmrh |=> TMR_REQ_OUT
        && LOC_OFF_OUT == $past(CYC_ADDR_IN[5:0])) else $error("timer miss");
    a_wide_drop: assert property (
        CYC_VALID_IN && win && !byt |=> CYC_DROP_OUT)
        else $error("wide cycle taken");
    a_io_forward: assert property (
        CYC_VALID_IN && !CYC_MEM_IN && !win |=> ISA_IO_REQ_OUT
        && ISA_ADDR_OUT == {8'h00, $past(CYC_ADDR_IN[15:0])})
        else $error("io not forwarded");
    a_mem_forward: assert property (
        CYC_VALID_IN && CYC_MEM_IN && low |=> ISA_MEM_REQ_OUT
        && ISA_ADDR_OUT == $past(CYC_ADDR_IN[23:0]))
        else $error("memory not forwarded");
    a_mem_ignore: assert property (
        CYC_VALID_IN && CYC_MEM_IN && !low |=> CYC_DROP_OUT)
        else $error("high memory taken");
    a_status_sticky: assert property (
        1'b1 |=> SRC_STAT_OUT == (($past(SRC_STAT_OUT)
        & ~$past(SRC_CLR_IN)) | $past(SRC_EVT_IN)))
        else $error("status lost");
    a_enable_load: assert property (
        ISA_EN_WR_IN |=> ISA_EN_OUT == $past(ISA_EN_WDATA_IN))
        else $error("enable not loaded");
    a_slot_pulse: assert property (
        $rose(SERIRQ_OE_OUT) |=> !SERIRQ_OE_OUT [*2])
        else $error("slot drive too long");
endmodule

bind bib_top bib_top_checker #(.NSRC(NSRC)) u_chk (.*);

// ### tb/bib_host_model.sv
// host side model: issues serial irq start frames
`timescale 1ns/1ns
module bib_host_model (
    input  wire clk_in,               // system clock
    input  wire go_in,                // request one start frame
    output reg  pull_low_out = 1'b0   // high while pulling line low
);
    int cnt = 0;                      // start clocks still to run
    // six low clocks, then release to the pull-up
    always @(posedge clk_in) begin
        if (go_in && cnt == 0) begin
            cnt <= 6;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
        pull_low_out <= (go_in && cnt == 0) || cnt > 1;
    end
endmodule

// ### tb/tb_top.sv
// self-checking bench for the lpc bridge
`timescale 1ns/1ns
module tb_top;
    logic        clk, rst_n, v, m, w, iwr, go;   // driven controls
    logic [1:0]  sz, uirq, uen;                  // size, uart irqs
    logic [31:0] a;                              // cycle address
    logic [7:0]  wd, evt, clr, en, st;           // st: status model
    logic [23:0] sel;                            // source line codes
    logic [5:0]  usel;                           // uart line codes
    logic [10:0] iirq, iwdat;                    // isa pins, enables
    wire         loc, tmr, iio, imem, drop, lw, iw, so, soe, hlow;
    wire [5:0]   off;
    wire [23:0]  ia;
    wire [7:0]   lwd, iwd, stat;
    wire [10:0]  ien;
    int          miscompares, total_checks;
    int          isa_no[11] = '{3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15};
    wire         pin = soe ? so : !hlow;         // pull-up when free
    bib_top #(.NSRC(8)) u_dut (
        .CLK_IN(clk), .RST_N_IN(rst_n), .CYC_VALID_IN(v), .CYC_MEM_IN(m),
        .CYC_WRITE_IN(w), .CYC_SIZE_IN(sz), .CYC_ADDR_IN(a),
        .CYC_WDATA_IN(wd), .LOC_REQ_OUT(loc), .TMR_REQ_OUT(tmr),
        .LOC_OFF_OUT(off), .LOC_WRITE_OUT(lw), .LOC_WDATA_OUT(lwd),
        .ISA_IO_REQ_OUT(iio), .ISA_MEM_REQ_OUT(imem), .ISA_ADDR_OUT(ia),
        .ISA_WRITE_OUT(iw), .ISA_WDATA_OUT(iwd), .CYC_DROP_OUT(drop),
        .SRC_EVT_IN(evt), .SRC_CLR_IN(clr), .SRC_EN_IN(en),
        .SRC_SEL_IN(sel), .SRC_STAT_OUT(stat), .UART_IRQ_IN(uirq),
        .UART_EN_IN(uen), .UART_SEL_IN(usel), .ISA_IRQ_IN(iirq),
        .ISA_EN_WR_IN(iwr), .ISA_EN_WDATA_IN(iwdat), .ISA_EN_OUT(ien),
        .SERIRQ_IN(pin), .SERIRQ_OUT(so), .SERIRQ_OE_OUT(soe));
    bib_host_model u_host (.clk_in(clk), .go_in(go), .pull_low_out(hlow));
    // ------------
    // reference model and compare
    // ------------
    function automatic int kind(input logic mm, input logic [31:0] ad,
                                input logic [1:0] s);
        if (mm) return (ad < 32'h0100_0000) ? 3 : 4;
        if (ad < 32'h0000_0C80 || ad > 32'h0000_0CBF) return 2;
        if (s != 2'h0) return 4;
        return (ad >= 32'h0000_0CBC) ? 1 : 0;
    endfunction
    function automatic int irqno(input logic [2:0] c);
        return (c < 3'h5) ? c + 3 : c + 4;
    endfunction
    task automatic chk(input string nm, input logic [39:0] e, g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one lpc cycle, answer checked one clock later
    task automatic cyc(input logic mm, input logic [31:0] ad,
                       input logic [1:0] s);
        int k;
        k = kind(mm, ad, s);
        {v, m, a, sz} = {1'b1, mm, ad, s};
        w = 1'($urandom);
        wd = 8'($urandom);
        @(negedge clk);
        chk("strobes", 40'(1 << k), {drop, imem, iio, tmr, loc});
        if (k < 2) chk("local", {w, wd, ad[5:0]}, {lw, lwd, off});
        if (k == 2) chk("isa_io", {w, wd, 8'h00, ad[15:0]},
                        {iw, iwd, ia});
        if (k == 3) chk("isa_mem", {w, wd, ad[23:0]}, {iw, iwd, ia});
    endtask
    // one serial irq frame, slot drives checked in order and spacing
    task automatic frame();
        logic [15:0] ac, pd;
        logic        e, p;
        logic [2:0]  c;
        int          ns, ps, pc, np;
        {ac, pd, ps, pc, np} = {32'h0, -32'sd1, 32'h0, 32'h0};
        for (int i = 0; i < 10; i++) begin
            e = i < 8 ? en[i] : uen[i-8];
            c = i < 8 ? sel[3*i+:3] : usel[3*(i-8)+:3];
            p = i < 8 ? st[i] : uirq[i-8];
            if (e) ac[irqno(c)] = 1'b1;
            if (e) pd[irqno(c)] |= p;
        end
        for (int j = 0; j < 11; j++) begin
            if (iwdat[j]) ac[isa_no[j]] = 1'b1;
            if (iwdat[j]) pd[isa_no[j]] |= iirq[j];
        end
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        for (int t = 0; t < 120; t++) begin
            @(negedge clk);
            if (soe === 1'b1) begin
                ns = ps + 1;
                while (ns < 16 && !ac[ns]) ns++;
                chk("slot_level", pd[ns], so);
                if (ps >= 0) chk("slot_gap", 3 * (ns - ps), t - pc);
                ps = ns;
                pc = t;
                np++;
            end
        end
        chk("slot_count", $countones(ac), np);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ------------
    // clock, watchdog and main sequence
    // ------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        {rst_n, v, m, w, iwr, go} = '0;
        {a, wd, evt, clr, en, st} = '0;
        {sz, uirq, uen, usel, iirq, iwdat, sel} = '0;
        void'($urandom(36));
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk("reset_en", 11'h0, ien);
        cyc(1'b0, 32'h0000_0C80, 2'h0);
        cyc(1'b0, 32'h0000_0C81, 2'h0);
        cyc(1'b0, 32'h0000_0CBB, 2'h0);
        cyc(1'b0, 32'h0000_0CBC, 2'h0);
        cyc(1'b0, 32'h0000_0CBF, 2'h0);
        cyc(1'b0, 32'h0000_0C7F, 2'h0);
        cyc(1'b0, 32'h0000_0CC0, 2'h0);
        cyc(1'b0, 32'h0000_0378, 2'h2);
        cyc(1'b0, 32'h0001_0C80, 2'h0);
        cyc(1'b0, 32'h0000_0C90, 2'h1);
        cyc(1'b1, 32'h000A_0000, 2'h0);
        cyc(1'b1, 32'h00FF_FFFF, 2'h0);
        cyc(1'b1, 32'h0100_0000, 2'h0);
        cyc(1'b1, 32'hFED4_0000, 2'h0);
        for (int i = 0; i < 16; i++) begin
            cyc(1'($urandom), 32'($urandom) & 32'h01FF_0FFF, 2'h0);
        end
        v = 1'b0;
        @(negedge clk);
        $display("test decode done");
        for (int i = 0; i < 12; i++) begin
            evt = 8'($urandom) & 8'($urandom);
            clr = 8'($urandom);
            st = (st & ~clr) | evt;
            @(negedge clk);
            chk("status", st, stat);
        end
        {evt, clr} = '0;
        $display("test status done");
        for (int f = 0; f < 3; f++) begin
            if (f != 1) begin
                {en, sel, uen, usel} = 40'({$urandom, $urandom});
                {uirq, iirq, iwdat} = 24'($urandom);
            end
            iwr = 1'b1;
            @(negedge clk);
            iwr = 1'b0;
            chk("isa_en", iwdat, ien);
            repeat (4) @(negedge clk);
            frame();
            $display("test frame %0d done", f);
        end
        tally_and_finish();
    end
endmodule
